// >>> emc_master_ctl.sv
// Notes on behaviour
// - sixteen-bit capability strobe rides with start
// - downshift on memory burst, ex32 off, slburst on
// - slave decode only while address enable low
// - address enable taken at command fall, master ignores
// - slburst sampled after start, burst strobe next fall
// - slburst negated gives non-burst or mismatched cycles
// - burst strobe never driven as slave, floats reset
// - lock held through whole locked exchange
// - drive bus on fall two bus clocks after grant
// - write request waits for full channel fifo
// - read request at once unless slave cycle active
// - bus request high after reset
// - grant sampled only on bus clock falling edges
// - release bus within 64 bus clocks of preemption
// - interrupt edge or level, open collector level
// - interrupt resets to level mode, floating
// - bus timing follows bus clock edges, stretch-safe, except mreq_n assert and xfer_done release
// - ex32 sampled at the rise that ends start
module emc_master_ctl #(
  parameter int RELEASE_BCLKS = emc_pkg::RELEASE_BCLKS
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // bus pins, inputs
  input  wire logic bclk,
  input  wire logic start_n_in,
  input  wire logic cmd_n,
  input  wire logic aen,
  input  wire logic slburst_n,
  input  wire logic ex32_n,
  input  wire logic mak_n,
  // bus pins, outputs, all but mreq_n with enables
  output logic      mreq_n,
  output logic      start_n_out,
  output logic      start_oe,
  output logic      master16_n_out,
  output logic      master16_oe,
  output logic      msburst_n_out,
  output logic      msburst_oe,
  output logic      lock_n_out,
  output logic      lock_oe,
  output logic      system_interrupt_out,
  output logic      system_interrupt_oe,
  // local transfer request
  input  wire logic xfer_req,
  input  wire logic xfer_write,
  input  wire logic xfer_mem_burst,
  input  wire logic xfer_locked,
  input  wire logic fifo_full,
  input  wire logic xfer_done,
  // local slave decode
  input  wire logic slave_addr_match,
  // local interrupt control
  input  wire logic irq_event,
  input  wire logic irq_clear,
  input  wire logic irq_mode_wr,
  input  wire logic irq_mode_edge,
  // status
  output logic      drive_bus,
  output logic      burst_mode,
  output logic      downshift16,
  output logic      mismatch_cycle,
  output logic      slave_io_select,
  output logic      preempted
);
  logic [emc_pkg::SYNC_W-1:0] sync_q;
  logic                       bclk_d;
  logic                       cmd_d;
  logic                       bclk_rise;
  logic                       bclk_fall;
  logic                       cmd_fall;
  logic                       cmd_rise;
  logic                       aen_s;
  logic                       slburst_s;
  logic                       ex32_s;
  logic                       mak_s;
  emc_pkg::emc_state_t        state;
  logic [emc_pkg::CNT_W-1:0]  cnt;
  logic                       start_on;
  logic                       master16_on;
  logic                       msburst_on;
  logic                       lock_on;
  logic                       slb_seen;
  logic                       x_mem;
  logic                       x_lock;
  logic                       owning;
  logic                       req_ok;
  logic                       irq_edge;
  logic                       irq_pending;

  // every bus pin passes two flops before use
  emc_sync #(
    .W       (emc_pkg::SYNC_W),
    .RST_VAL (emc_pkg::SYNC_RESET)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({mak_n, ex32_n, slburst_n, aen, cmd_n, start_n_in, bclk}),
    .q       (sync_q)
  );

  assign aen_s     = sync_q[emc_pkg::S_AEN];
  assign slburst_s = sync_q[emc_pkg::S_SLBURST];
  assign ex32_s    = sync_q[emc_pkg::S_EX32];
  assign mak_s     = sync_q[emc_pkg::S_MAK];

  // edges seen on the synchronised copies, so stretched periods are harmless
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bclk_d <= 1'b0;
      cmd_d  <= 1'b1;
    end else begin
      bclk_d <= sync_q[emc_pkg::S_BCLK];
      cmd_d  <= sync_q[emc_pkg::S_CMD];
    end
  end

  assign bclk_rise = sync_q[emc_pkg::S_BCLK] & ~bclk_d;
  assign bclk_fall = ~sync_q[emc_pkg::S_BCLK] & bclk_d;
  assign cmd_fall  = ~sync_q[emc_pkg::S_CMD] & cmd_d;
  assign cmd_rise  = sync_q[emc_pkg::S_CMD] & ~cmd_d;

  assign owning = (state != emc_pkg::EMC_IDLE) && (state != emc_pkg::EMC_REQ);
  // writes wait for a full fifo, reads only for a free slave side
  assign req_ok = xfer_req && (xfer_write ? fifo_full : !slave_io_select);

  // master cycle sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state          <= emc_pkg::EMC_IDLE;
      mreq_n         <= 1'b1;
      drive_bus      <= 1'b0;
      start_on       <= 1'b0;
      master16_on    <= 1'b0;
      msburst_on     <= 1'b0;
      lock_on        <= 1'b0;
      burst_mode     <= 1'b0;
      downshift16    <= 1'b0;
      mismatch_cycle <= 1'b0;
      slb_seen       <= 1'b0;
      x_mem          <= 1'b0;
      x_lock         <= 1'b0;
      preempted      <= 1'b0;
      cnt            <= '0;
    end else begin
      case (state)
        emc_pkg::EMC_IDLE: begin
          if (req_ok) begin
            mreq_n <= 1'b0;
            x_mem  <= xfer_mem_burst;
            x_lock <= xfer_locked;
            state  <= emc_pkg::EMC_REQ;
          end
        end
        emc_pkg::EMC_REQ: begin
          if (bclk_fall && !mak_s) begin
            cnt   <= '0;
            state <= emc_pkg::EMC_GRANT;
          end
        end
        emc_pkg::EMC_GRANT: begin
          if (bclk_fall) begin
            if (cnt == emc_pkg::CNT_W'(emc_pkg::GRANT_DELAY_BCLKS - 1)) begin
              // address and lock lead, start follows on the next rise
              drive_bus <= 1'b1;
              lock_on   <= x_lock;
              cnt       <= '0;
              state     <= emc_pkg::EMC_START;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        end
        emc_pkg::EMC_START: begin
          // start spans one full period, rise to rise
          if (bclk_rise && !start_on) begin
            start_on    <= 1'b1;
            master16_on <= x_mem;
          end
          if (bclk_rise && start_on) begin
            start_on       <= 1'b0;
            master16_on    <= 1'b0;
            slb_seen       <= !slburst_s;
            burst_mode     <= !slburst_s;
            downshift16    <= !slburst_s && ex32_s && x_mem;
            mismatch_cycle <= slburst_s && ex32_s;
            state          <= emc_pkg::EMC_DATA;
          end
        end
        emc_pkg::EMC_DATA: begin
          // burst strobe on the first fall after start ends
          if (bclk_fall && slb_seen) begin
            msburst_on <= 1'b1;
          end
          // grant drop is only a request; we finish or give up in time
          if (bclk_fall && mak_s) begin
            preempted <= 1'b1;
          end
          if (bclk_fall && preempted) begin
            cnt <= cnt + 1'b1;
          end
          if (xfer_done || (bclk_fall && preempted &&
              cnt == emc_pkg::CNT_W'(RELEASE_BCLKS - 2))) begin
            mreq_n         <= 1'b1;
            drive_bus      <= 1'b0;
            msburst_on     <= 1'b0;
            lock_on        <= 1'b0;
            burst_mode     <= 1'b0;
            downshift16    <= 1'b0;
            mismatch_cycle <= 1'b0;
            preempted      <= 1'b0;
            state          <= emc_pkg::EMC_IDLE;
          end
        end
        default: begin
          state <= emc_pkg::EMC_IDLE;
        end
      endcase
    end
  end

  // slave decode, address enable taken at command fall only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slave_io_select <= 1'b0;
    end else if (cmd_fall) begin
      slave_io_select <= !aen_s && slave_addr_match && !owning;
    end else if (cmd_rise) begin
      slave_io_select <= 1'b0;
    end
  end

  // interrupt mode and pending flag; a new event beats a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_edge    <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      if (irq_mode_wr) begin
        irq_edge <= irq_mode_edge;
      end
      if (irq_event) begin
        irq_pending <= 1'b1;
      end else if (irq_clear) begin
        irq_pending <= 1'b0;
      end
    end
  end

  // pin drivers; open-collector pins only ever pull low
  assign start_n_out          = !start_on;
  assign start_oe             = drive_bus;
  assign master16_n_out       = 1'b0;
  assign master16_oe          = master16_on;
  assign msburst_n_out        = !msburst_on;
  assign msburst_oe           = drive_bus;
  assign lock_n_out           = !lock_on;
  assign lock_oe              = drive_bus;
  assign system_interrupt_out = irq_edge ? irq_pending : 1'b0;
  assign system_interrupt_oe  = irq_edge ? 1'b1 : irq_pending;

  property p_master16_with_start;
    @(posedge clk_sys) disable iff (rst)
      master16_oe |-> (start_oe && !start_n_out);
  endproperty
  master16_start_a: assert property (p_master16_with_start)
    else $error("sixteen-bit strobe without start");

  // independent counts, so the timing checks do not reuse the logic
  logic [emc_pkg::CNT_W-1:0] rel_falls;
  logic [1:0]                start_rises;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rel_falls <= '0;
    end else if (!preempted) begin
      rel_falls <= '0;
    end else if (bclk_fall) begin
      rel_falls <= rel_falls + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_rises <= '0;
    end else if (!start_on) begin
      start_rises <= '0;
    end else if (bclk_rise) begin
      start_rises <= start_rises + 2'h1;
    end
  end

  start_len_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $fell(start_on) |-> start_rises == 2'h1)
    else $error("start not held for one bus clock");

  downshift_cond_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $rose(downshift16) |-> burst_mode && x_mem && $past(ex32_s))
    else $error("downshift outside memory burst");

  slave_aen_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $rose(slave_io_select) |-> $past(cmd_fall && !aen_s))
    else $error("slave select without address enable low at command");

  master_ignore_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $past(owning) |-> !$rose(slave_io_select))
    else $error("slave decode while bus master");

  msburst_fall_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $rose(msburst_on) |-> $past(bclk_fall) && slb_seen)
    else $error("burst strobe off a falling edge");

  no_burst_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      (state == emc_pkg::EMC_DATA && !burst_mode) |-> !msburst_on)
    else $error("burst strobe in non-burst cycle");

  msburst_slave_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      !owning |-> !msburst_oe)
    else $error("burst strobe driven as slave");

  lock_hold_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      (state == emc_pkg::EMC_DATA && x_lock) |-> (lock_oe && !lock_n_out))
    else $error("lock dropped inside exchange");

  grant_drive_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $rose(drive_bus) |-> $past(bclk_fall) && !mreq_n)
    else $error("bus driven off a falling edge");

  req_gate_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      $fell(mreq_n) |-> $past(xfer_write ? fifo_full : !slave_io_select))
    else $error("bus request without its condition");

  idle_mreq_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      (state == emc_pkg::EMC_IDLE) |-> mreq_n)
    else $error("bus request while idle");

  release_bound_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      preempted |-> rel_falls < emc_pkg::CNT_W'(RELEASE_BCLKS - 1))
    else $error("bus held too long after preemption");

  irq_float_a: assert property (
    @(posedge clk_sys) disable iff (rst)
      (!irq_edge && !irq_pending) |-> !system_interrupt_oe)
    else $error("level interrupt driven while idle");

  burst_c: cover property (@(posedge clk_sys) disable iff (rst)
      $rose(burst_mode));
  downshift_c: cover property (@(posedge clk_sys) disable iff (rst)
      $rose(downshift16));
  preempt_c: cover property (@(posedge clk_sys) disable iff (rst)
      preempted ##1 !preempted);
  slave_c: cover property (@(posedge clk_sys) disable iff (rst)
      $rose(slave_io_select));
endmodule // emc_master_ctl

// >>> emc_sync.sv
package emc_pkg;
  // bus clock figures: nominal 8.33 MHz, local clock 50 MHz
  localparam int SYS_PERIOD_PS   = 20000;
  localparam int BCLK_PERIOD_PS  = 120000;
  // local cycles per nominal bus clock, rounded down
  localparam int CLKS_PER_BCLK   = BCLK_PERIOD_PS / SYS_PERIOD_PS;
  // bus clock edges from grant sampled to driving the bus
  localparam int GRANT_DELAY_BCLKS = 2;
  // longest hold of the bus after preemption, in bus clocks
  localparam int RELEASE_BCLKS   = 64;
  // width of the bus clock edge counter
  localparam int CNT_W           = 7;
  // number of pin inputs passing through the synchroniser
  localparam int SYNC_W          = 7;
  // synchroniser bit positions
  localparam int S_BCLK          = 0;
  localparam int S_START         = 1;
  localparam int S_CMD           = 2;
  localparam int S_AEN           = 3;
  localparam int S_SLBURST       = 4;
  localparam int S_EX32          = 5;
  localparam int S_MAK           = 6;
  // reset value of all active-low pins held idle
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h7E;

  typedef enum logic [2:0] {
    EMC_IDLE,
    EMC_REQ,
    EMC_GRANT,
    EMC_START,
    EMC_DATA
  } emc_state_t;
endpackage

module emc_sync #(
  parameter int W = emc_pkg::SYNC_W,
  parameter logic [W-1:0] RST_VAL = emc_pkg::SYNC_RESET
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // asynchronous inputs and their synchronised copies
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // emc_sync

// >>> emc_bus_partner.sv
module emc_bus_partner (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // scenario controls
  input  wire logic grant_en,
  input  wire logic stretch,
  input  wire logic slb_cfg_n,
  input  wire logic ex32_cfg_n,
  // bus side
  input  wire logic mreq_n,
  input  wire logic start_oe,
  output logic      bclk,
  output logic      mak_n,
  output logic      slburst_n,
  output logic      ex32_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] ph;

  // six local cycles a period; stretch adds one whole period to the low half
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph   <= 4'h0;
      bclk <= 1'b0;
    end else if (ph == ((!bclk && stretch) ? 4'h8 : 4'h2)) begin
      ph   <= 4'h0;
      bclk <= ~bclk;
    end else begin
      ph <= ph + 4'h1;
    end
  end

  // grant follows the request; withdrawn to preempt the owner
  always_ff @(posedge bclk or posedge rst) begin
    if (rst) begin
      mak_n <= 1'b1;
    end else begin
      mak_n <= !(!mreq_n && grant_en);
    end
  end

  // slave answers only during a master cycle, else the pull-up wins
  assign slburst_n = start_oe ? slb_cfg_n : 1'b1;
  assign ex32_n    = start_oe ? ex32_cfg_n : 1'b1;
endmodule // emc_bus_partner

// >>> emc_master_ctl_tb_top.sv
module emc_master_ctl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int REL = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic bclk, mak_n, slburst_n, ex32_n, cmd_n, aen, start_n_in, seen;
  logic grant_en, stretch, slb_cfg_n, ex32_cfg_n;
  logic mreq_n, start_n_out, start_oe, master16_n_out, master16_oe;
  logic msburst_n_out, msburst_oe, lock_n_out, lock_oe;
  logic system_interrupt_out, system_interrupt_oe;
  logic xfer_req, xfer_write, xfer_mem_burst, xfer_locked, fifo_full;
  logic xfer_done, slave_addr_match, irq_event, irq_clear, irq_mode_wr;
  logic irq_mode_edge, drive_bus, burst_mode, downshift16, mismatch_cycle;
  logic slave_io_select, preempted;
  int failures = 0;
  int samples_checked = 0;

  always #10 clk_sys = ~clk_sys;

  emc_master_ctl #(.RELEASE_BCLKS(REL)) i_emc_master_ctl (
    .clk_sys, .rst, .bclk, .start_n_in, .cmd_n, .aen, .slburst_n,
    .ex32_n, .mak_n, .mreq_n, .start_n_out, .start_oe, .master16_n_out,
    .master16_oe, .msburst_n_out, .msburst_oe, .lock_n_out, .lock_oe,
    .system_interrupt_out, .system_interrupt_oe, .xfer_req, .xfer_write,
    .xfer_mem_burst, .xfer_locked, .fifo_full, .xfer_done,
    .slave_addr_match, .irq_event, .irq_clear, .irq_mode_wr,
    .irq_mode_edge, .drive_bus, .burst_mode, .downshift16,
    .mismatch_cycle, .slave_io_select, .preempted);

  emc_bus_partner i_emc_bus_partner (
    .clk_sys, .rst, .grant_en, .stretch, .slb_cfg_n, .ex32_cfg_n,
    .mreq_n, .start_oe, .bclk, .mak_n, .slburst_n, .ex32_n);

  task automatic check(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // bounded wait, so a stuck output fails instead of hanging
  task automatic wait_lvl(string what, ref logic s, input logic v,
                          input int n);
    for (int i = 0; i < n && s !== v; i++) cyc(1);
    check(what, v, s);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask

  task automatic stop_test;
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic t_reset;
    check("mreq_n", 1'b1, mreq_n);
    check("msburst_oe", 1'b0, msburst_oe);
    check("irq_oe", 1'b0, system_interrupt_oe);
    check("lock_oe", 1'b0, lock_oe);
  endtask

  task automatic t_read_burst;
    int n;
    {slb_cfg_n, ex32_cfg_n, xfer_mem_burst, xfer_req} = 4'h7;
    cyc(1);
    check("mreq_n", 1'b0, mreq_n);
    xfer_req = 1'b0;
    wait_lvl("mak_n", mak_n, 1'b0, 40);
    n = 0;
    while (drive_bus !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check("grant delay", 1'b1, n >= 14 && n <= 21);
    check("start_n_out", 1'b1, start_n_out);
    wait_lvl("start_n_out", start_n_out, 1'b0, 10);
    check("master16_oe", 1'b1, master16_oe);
    n = 0;
    while (start_n_out !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check("start period", 1'b1, n == 6);
    check("master16_oe", 1'b0, master16_oe);
    // burst strobe lands on the fall after start ends
    cyc(4);
    check("msburst_n_out", 1'b0, msburst_n_out);
    check("msburst_oe", 1'b1, msburst_oe);
    check("burst_mode", 1'b1, burst_mode);
    check("downshift16", 1'b1, downshift16);
    check("mismatch_cycle", 1'b0, mismatch_cycle);
    pulse(xfer_done);
    check("mreq_n", 1'b1, mreq_n);
    check("msburst_oe", 1'b0, msburst_oe);
  endtask

  // write, locked, non-burst, bus clock stretched, then preempted
  task automatic t_write_lock;
    int n;
    {slb_cfg_n, xfer_mem_burst, xfer_write, xfer_locked} = 4'hB;
    {stretch, xfer_req} = 2'h3;
    cyc(10);
    check("mreq_n", 1'b1, mreq_n);
    fifo_full = 1'b1;
    cyc(1);
    check("mreq_n", 1'b0, mreq_n);
    xfer_req = 1'b0;
    wait_lvl("drive_bus", drive_bus, 1'b1, 200);
    wait_lvl("start_n_out", start_n_out, 1'b0, 20);
    check("master16_oe", 1'b0, master16_oe);
    n = 0;
    while (start_n_out !== 1'b1 && n < 30) begin
      cyc(1);
      n++;
    end
    check("stretched start", 1'b1, n == 12);
    cyc(4);
    check("lock_n_out", 1'b0, lock_n_out);
    check("msburst_n_out", 1'b1, msburst_n_out);
    check("burst_mode", 1'b0, burst_mode);
    check("mismatch_cycle", 1'b1, mismatch_cycle);
    check("downshift16", 1'b0, downshift16);
    {grant_en, seen} = 2'h0;
    // stretched period is 12 cycles; release due REL-1 falls after the loss
    for (int i = 0; i < 12 * (REL + 1) && mreq_n !== 1'b1; i++) begin
      if (preempted === 1'b1) seen = 1'b1;
      cyc(1);
    end
    check("preempted", 1'b1, seen);
    check("mreq_n", 1'b1, mreq_n);
    cyc(1);
    check("lock_oe", 1'b0, lock_oe);
    {grant_en, stretch, xfer_write, xfer_locked, fifo_full} = 5'h10;
    cyc(12);
  endtask

  task automatic t_slave;
    {slave_addr_match, aen, cmd_n} = 3'h4;
    cyc(1);
    aen = 1'b1;
    cyc(5);
    check("slave_io_select", 1'b1, slave_io_select);
    xfer_req = 1'b1;
    cyc(3);
    check("mreq_n", 1'b1, mreq_n);
    {xfer_req, cmd_n} = 2'h1;
    cyc(5);
    check("slave_io_select", 1'b0, slave_io_select);
    cmd_n = 1'b0;
    cyc(6);
    check("slave_io_select", 1'b0, slave_io_select);
    cmd_n = 1'b1;
    cyc(5);
  endtask

  task automatic t_irq;
    pulse(irq_event);
    check("irq_oe", 1'b1, system_interrupt_oe);
    check("irq_out", 1'b0, system_interrupt_out);
    pulse(irq_clear);
    check("irq_oe", 1'b0, system_interrupt_oe);
    irq_mode_edge = 1'b1;
    pulse(irq_mode_wr);
    check("irq_oe", 1'b1, system_interrupt_oe);
    check("irq_out", 1'b0, system_interrupt_out);
    pulse(irq_event);
    check("irq_out", 1'b1, system_interrupt_out);
    pulse(irq_clear);
    check("irq_out", 1'b0, system_interrupt_out);
  endtask

  // about 235 cycles of tests; the limit leaves wide margin
  initial begin
    #100us;
    failures++;
    stop_test();
  end

  initial begin
    {cmd_n, start_n_in, grant_en, slb_cfg_n, ex32_cfg_n} = 5'h1F;
    {aen, stretch, slave_addr_match, irq_mode_edge} = 4'h0;
    {xfer_req, xfer_write, xfer_mem_burst, xfer_locked} = 4'h0;
    {fifo_full, xfer_done, irq_event, irq_clear, irq_mode_wr} = 5'h00;
    cyc(20);
    rst = 1'b0;
    cyc(4);
    t_reset();
    t_read_burst();
    t_write_lock();
    t_slave();
    t_irq();
    stop_test();
  end
endmodule // emc_master_ctl_tb_top
